// ---- logic/alu_if.sv ----
// Carrier between the execution top and its arithmetic unit.
// Assumes both ends sit in the same clock domain.
`timescale 1ns/1ps

interface alu_if;
    exec_pkg::op_t op;      // Selected operation
    logic [7:0]    f_val;   // File register operand
    logic [7:0]    w_val;   // Working register operand
    logic [7:0]    result;  // Result byte
    logic          carry;   // No borrow out of bit 7
    logic          dcarry;  // No borrow out of bit 3
    logic          zero;    // Difference f - w is zero

    modport core (output op, f_val, w_val, input result, carry, dcarry, zero);
    modport alu  (input op, f_val, w_val, output result, carry, dcarry, zero);
endinterface : alu_if

// ---- logic/exec_alu.sv ----
// Combinational arithmetic for subtract and nibble swap.
// Assumes operands are stable for the whole cycle.
`timescale 1ns/1ps

module exec_alu (
    alu_if.alu a    // Operands in, result and flags out
);

    logic [8:0] diff;   // Full difference with borrow column
    logic [4:0] ldiff;  // Low nibble difference

    // Two's complement subtract f - w; a set top bit means no borrow
    always_comb begin
        diff  = {1'b0, a.f_val} + {1'b0, ~a.w_val} + 9'h001; // RULE1
        ldiff = {1'b0, a.f_val[3:0]} + {1'b0, ~a.w_val[3:0]} + 5'h01;
    end

    // Result mux and flags
    always_comb begin
        a.result = diff[7:0];
        if (a.op == exec_pkg::OP_SWAP) begin
            a.result = {a.f_val[3:0], a.f_val[7:4]}; // RULE4
        end else if (a.op == exec_pkg::OP_DIR) begin
            a.result = a.w_val;
        end
        a.carry  = diff[8];   // RULE3
        a.dcarry = ldiff[4];
        a.zero   = (diff[7:0] == 8'h00);
    end

endmodule : exec_alu

// ---- logic/exec_cfg.svh ----
// Offsets, field positions, reset values and opcode patterns for the
// subtract / nibble-swap / direction-load execution block.
// Assumes a 32-bit Avalon-MM register window with byte addresses.
`ifndef EXEC_CFG_SVH
`define EXEC_CFG_SVH

// ********************************************
// Register byte offsets
// ********************************************
`define CFG_ADDR_CTRL     5'h00
`define CFG_ADDR_WREG     5'h04
`define CFG_ADDR_STATUS   5'h08
`define CFG_ADDR_DIR5     5'h0c
`define CFG_ADDR_DIR6     5'h10
`define CFG_ADDR_DIR7     5'h14

// ********************************************
// Field positions and reset values
// ********************************************
`define CFG_CTRL_EN_BIT   0
`define CFG_CTRL_RST      1'h1
`define CFG_STAT_C_BIT    0
`define CFG_STAT_DC_BIT   1
`define CFG_STAT_Z_BIT    2
`define CFG_STAT_RST      3'h0
`define CFG_WREG_RST      8'h00
`define CFG_DIR_RST       8'hff

// ********************************************
// Opcode patterns
// ********************************************
`define CFG_OPC_SUB       6'h02
`define CFG_OPC_SWAP      6'h0e
`define CFG_OPC_DIR_HI    9'h000
`define CFG_DIR_FIRST     3'h5

`endif

// ---- logic/exec_pkg.sv ----
// Types shared by the execution block and its arithmetic unit.
// Assumes exec_cfg.svh supplies the opcode patterns.
`include "exec_cfg.svh"

package exec_pkg;

    // ********************************************
    // Operation select, one-hot
    // ********************************************
    typedef enum logic [3:0] {
        OP_NONE = 4'b0001,
        OP_SUB  = 4'b0010,
        OP_SWAP = 4'b0100,
        OP_DIR  = 4'b1000
    } op_t;

    // Decode one 12-bit program word
    function automatic op_t decode_op(input logic [11:0] instr);
        op_t op;
        op = OP_NONE;
        if (instr[11:6] == `CFG_OPC_SUB) begin
            op = OP_SUB;
        end else if (instr[11:6] == `CFG_OPC_SWAP) begin
            op = OP_SWAP;
        end else if (instr[11:3] == `CFG_OPC_DIR_HI && instr[2:0] >= `CFG_DIR_FIRST) begin
            op = OP_DIR;
        end
        return op;
    endfunction : decode_op

endpackage : exec_pkg

// ---- logic/subtract_swap_dirload_exec.sv ----
// Execution block for subtract-w-from-file, swap-file-nibbles and
// load-port-direction, with an Avalon-MM register window.
// Assumes the decoder presents one program word per valid cycle together
// with the current value of the file register that word addresses.
// A file result reaches the file space one cycle after its word is taken.
//
// Notes on behaviour
// [RULE1] Subtract decoded by its pattern computes file minus working, two's complement.
// [RULE2] Subtract result goes to working when d is 0, to file when 1.
// [RULE3] Subtract sets carry when no borrow, and updates digit carry and zero.
// [RULE4] Swap decoded by its pattern exchanges file nibbles and leaves flags alone.
// [RULE5] Swap result goes to working when d is 0, to file when 1.
// [RULE6] Direction load copies working into the direction register of port 5, 6 or 7.
// [RULE7] Direction load has nine zero top bits; the low three pick the port.
// [RULE8] Carry sits in bit 0 of the status register.
// [RULE9] Each instruction takes one word and one cycle; results seen by the next.
`timescale 1ns/1ps
`include "exec_cfg.svh"

module subtract_swap_dirload_exec (
    input  wire logic        i_clk,              // Core clock, 200 MHz
    input  wire logic        i_rst_b,            // Synchronous reset, active low
    input  wire logic        i_instr_valid,      // Program word present this cycle
    input  wire logic [11:0] i_instr,            // Program word
    input  wire logic [7:0]  i_file_rdata,       // Value of addressed file register
    output logic             o_file_we,          // File write strobe, one cycle
    output logic [4:0]       o_file_waddr,       // File write address
    output logic [7:0]       o_file_wdata,       // File write data
    output logic [7:0]       o_wreg,             // Working register
    output logic [2:0]       o_status,           // Zero, digit carry, carry
    output logic [7:0]       o_dir5,             // Port 5 direction latch
    output logic [7:0]       o_dir6,             // Port 6 direction latch
    output logic [7:0]       o_dir7,             // Port 7 direction latch
    input  wire logic [4:0]  i_avs_address,      // Byte address
    input  wire logic        i_avs_read,         // Read request
    input  wire logic        i_avs_write,        // Write request
    input  wire logic [31:0] i_avs_writedata,    // Write data
    input  wire logic [3:0]  i_avs_byteenable,   // Byte lanes
    output logic [31:0]      o_avs_readdata,     // Read data
    output logic             o_avs_waitrequest   // Stall until answer
);

    // ********************************************
    // State
    // ********************************************
    logic             en_q;
    logic [7:0]       w_q;
    logic [2:0]       stat_q;
    logic [7:0]       dir_q [3];
    logic             we_q;
    logic [4:0]       waddr_q;
    logic [7:0]       wdata_q;
    logic             ack_q;
    logic [31:0]      rdata_q;
    exec_pkg::op_t    op;
    logic             go;
    logic             dest_file;
    logic [7:0]       f_val;
    logic [1:0]       dsel;
    logic             bus_wr;
    logic             lane0;
    alu_if            a ();

    // ********************************************
    // Decode and operand selection
    // ********************************************

    // True for the two operations whose result byte is steered by d
    function automatic logic has_result(input exec_pkg::op_t op_sel);
        return (op_sel == exec_pkg::OP_SUB) || (op_sel == exec_pkg::OP_SWAP);
    endfunction : has_result

    // Pick the operation; a word that reads the file still being written
    // takes the pending byte, since the file space lands it one edge late
    always_comb begin
        op        = exec_pkg::decode_op(i_instr); // RULE1 RULE4 RULE7
        go        = i_instr_valid & en_q & (op != exec_pkg::OP_NONE);
        dest_file = i_instr[5];
        dsel      = 2'(i_instr[2:0] - `CFG_DIR_FIRST);
        f_val     = i_file_rdata;
        if (we_q && waddr_q == i_instr[4:0]) begin
            f_val = wdata_q; // RULE9
        end
    end

    // Feed the arithmetic unit
    always_comb begin
        a.op    = op;
        a.f_val = f_val;
        a.w_val = w_q;
    end

    exec_alu u_alu (
        .a (a)
    );

    // ********************************************
    // Bus strobes
    // ********************************************

    // A write commits on the edge where waitrequest is low
    always_comb begin
        bus_wr = i_avs_write & ack_q;
        lane0  = i_avs_byteenable[0];
    end

    // ********************************************
    // Control register
    // ********************************************

    // Execution enable
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            en_q <= `CFG_CTRL_RST;
        end else if (bus_wr && lane0 && i_avs_address == `CFG_ADDR_CTRL) begin
            en_q <= i_avs_writedata[`CFG_CTRL_EN_BIT];
        end
    end

    // ********************************************
    // Working register, instruction wins over bus
    // ********************************************
    // A bus load in the same cycle as a result for W is dropped
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            w_q <= `CFG_WREG_RST;
        end else if (go && !dest_file && has_result(op)) begin
            w_q <= a.result; // RULE2 RULE5 RULE9
        end else if (bus_wr && lane0 && i_avs_address == `CFG_ADDR_WREG) begin
            w_q <= i_avs_writedata[7:0];
        end
    end

    // ********************************************
    // Status flags, instruction wins over bus
    // ********************************************
    // Of the instructions only subtract writes the flags; swap and direction load keep them
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            stat_q <= `CFG_STAT_RST;
        end else if (go && op == exec_pkg::OP_SUB) begin
            stat_q[`CFG_STAT_C_BIT]  <= a.carry; // RULE3 RULE8
            stat_q[`CFG_STAT_DC_BIT] <= a.dcarry;
            stat_q[`CFG_STAT_Z_BIT]  <= a.zero;
        end else if (bus_wr && lane0 && i_avs_address == `CFG_ADDR_STATUS) begin
            stat_q <= i_avs_writedata[2:0];
        end
    end

    // ********************************************
    // Port direction latches
    // ********************************************
    // Operands below 5 never decode, so dsel only reaches the three latches
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            for (int i = 0; i < 3; i++) begin
                dir_q[i] <= `CFG_DIR_RST;
            end
        end else if (go && op == exec_pkg::OP_DIR) begin
            dir_q[dsel] <= w_q; // RULE6 RULE7
        end
    end

    // ********************************************
    // File write-back
    // ********************************************
    // Address and data follow every taken word; the strobe marks real writes
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            we_q    <= 1'b0;
            waddr_q <= 5'h00;
            wdata_q <= 8'h00;
        end else begin
            we_q <= go && dest_file && has_result(op); // RULE2 RULE5
            if (go) begin
                waddr_q <= i_instr[4:0];
                wdata_q <= a.result;
            end
        end
    end

    // ********************************************
    // Avalon-MM answer: one wait cycle, then ack
    // ********************************************
    // Read data is captured in the wait cycle and stands until the next read
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            ack_q   <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else begin
            ack_q <= (i_avs_read | i_avs_write) & ~ack_q;
            if (i_avs_read && !ack_q) begin
                unique case (i_avs_address)
                    `CFG_ADDR_CTRL:   rdata_q <= {31'h0, en_q};
                    `CFG_ADDR_WREG:   rdata_q <= {24'h0, w_q};
                    `CFG_ADDR_STATUS: rdata_q <= {29'h0, stat_q};
                    `CFG_ADDR_DIR5:   rdata_q <= {24'h0, dir_q[0]};
                    `CFG_ADDR_DIR6:   rdata_q <= {24'h0, dir_q[1]};
                    `CFG_ADDR_DIR7:   rdata_q <= {24'h0, dir_q[2]};
                    default:          rdata_q <= 32'h0000_0000;
                endcase
            end
        end
    end

    // ********************************************
    // Outputs
    // ********************************************
    always_comb begin
        o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack_q;
        o_avs_readdata    = rdata_q;
        o_file_we         = we_q;
        o_file_waddr      = waddr_q;
        o_file_wdata      = wdata_q;
        o_wreg            = w_q;
        o_status          = stat_q;
        o_dir5            = dir_q[0];
        o_dir6            = dir_q[1];
        o_dir7            = dir_q[2];
    end

    // ********************************************
    // Checks
    // ********************************************
    logic [3:0] f_lo;
    logic [3:0] f_hi;
    logic [3:0] w_lo;
    logic       do_sub;
    logic       do_swap;
    logic       do_dir5;
    logic       do_dir67;
    logic       do_dir;
    logic       quiet;

    // Helper views for the checks; bus writes are kept out of the quiet cases
    always_comb begin
        f_lo     = f_val[3:0];
        f_hi     = f_val[7:4];
        w_lo     = w_q[3:0];
        do_sub   = go && op == exec_pkg::OP_SUB;
        do_swap  = go && op == exec_pkg::OP_SWAP;
        do_dir5  = go && op == exec_pkg::OP_DIR && dsel == 2'h0;
        do_dir67 = go && op == exec_pkg::OP_DIR && dsel != 2'h0;
        do_dir   = go && op == exec_pkg::OP_DIR && !i_avs_write;
        quiet    = i_instr_valid && !go && !i_avs_write;
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);

    // Subtract: destination, result and the three flags
    a_sub_to_w: assert property (do_sub && !dest_file |=> // RULE1 RULE2
        w_q == 8'($past(f_val) - $past(w_q)) && !o_file_we)
        else $error("subtract result to working register wrong");
    a_sub_to_file: assert property (do_sub && dest_file |=> // RULE2 RULE9
        o_file_we && o_file_wdata == 8'($past(f_val) - $past(w_q)) && $stable(w_q))
        else $error("subtract result to file wrong");
    a_sub_carry: assert property (do_sub |=> // RULE3 RULE8
        o_status[0] == ($past(f_val) >= $past(w_q)))
        else $error("carry does not match borrow");
    a_sub_dc_zero: assert property (do_sub |=> // RULE3
        o_status[1] == ($past(f_lo) >= $past(w_lo)) && o_status[2] == ($past(f_val) == $past(w_q)))
        else $error("digit carry or zero wrong");

    // Swap: both destinations, flags untouched
    a_swap_to_w: assert property (do_swap && !dest_file |=> // RULE4 RULE5
        w_q == {$past(f_lo), $past(f_hi)})
        else $error("swap result to working register wrong");
    a_swap_to_file: assert property (do_swap && dest_file |=> // RULE5
        o_file_we && o_file_wdata == {$past(f_lo), $past(f_hi)})
        else $error("swap result to file wrong");
    a_swap_flags: assert property (do_swap |=> $stable(o_status)) // RULE4
        else $error("swap changed flags");
    a_swap_w_only: assert property (do_swap && !dest_file |=> !o_file_we) // RULE5
        else $error("swap to working register also wrote the file");

    // Direction load: selected latch loaded; o_dir6 held on a port 5 load, o_dir5 on a port 6 or 7 load
    a_dir_load: assert property (do_dir5 |=> o_dir5 == $past(w_q) && $stable(o_dir6)) // RULE6 RULE7
        else $error("direction latch not loaded");
    a_dir_load_hi: assert property (do_dir67 |=> // RULE6 RULE7
        ($past(dsel) == 2'h1 ? o_dir6 : o_dir7) == $past(w_q) && $stable(o_dir5))
        else $error("upper direction latch not loaded");
    a_dir_no_side: assert property (do_dir |=> $stable(o_wreg) && $stable(o_status) && !o_file_we) // RULE6
        else $error("direction load disturbed other state");

    // Refused words and operands outside 5 to 7 leave no trace
    a_refused_quiet: assert property (quiet |=> // RULE6 RULE7
        !o_file_we && $stable(o_wreg) && $stable(o_status) && $stable({o_dir5, o_dir6, o_dir7}))
        else $error("refused word changed state");

    // ********************************************
    // Checks: bus
    // ********************************************

    // One wait state, then the answer
    a_bus_answer: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
        else $error("bus answer late");

    // Scenarios worth seeing
    c_sub_w:   cover property (do_sub && !dest_file);
    c_sub_zero: cover property (do_sub && a.zero);
    c_swap_f:  cover property (do_swap && dest_file);
    c_dir:     cover property (go && op == exec_pkg::OP_DIR);
    c_forward: cover property (i_instr_valid && we_q && waddr_q == i_instr[4:0]);

endmodule : subtract_swap_dirload_exec

// ---- test/file_space_model.sv ----
// File register space seen by the execution block: read by address, written on the strobe.
// Assumes the bench fills the array before the first instruction.
`timescale 1ns/1ps

module file_space_model (
    input  wire logic       i_clk,      // Core clock
    input  wire logic       i_valid,    // Word presented by the decoder
    input  wire logic [4:0] i_raddr,    // Addressed file register
    output logic [7:0]      o_rdata,    // Its current value
    input  wire logic       i_we,       // Write strobe from the block
    input  wire logic [4:0] i_waddr,    // Write address
    input  wire logic [7:0] i_wdata     // Write data
);
    logic [7:0] mem [0:31];

    // Read port shows garbage, not a held value, when no word is presented
    assign o_rdata = i_valid ? mem[i_raddr] : ~mem[i_raddr];

    // Write lands at the edge that ends the strobe cycle
    always @(posedge i_clk) begin
        if (i_we) begin
            mem[i_waddr] <= i_wdata;
        end
    end
endmodule : file_space_model

// ---- test/subtract_swap_dirload_exec_tb.sv ----
// Bench for the execution block: instruction driver, bus master, result monitor.
// Assumes one clock and a file space model answering the read port.
`timescale 1ns/1ps

module subtract_swap_dirload_exec_tb;
    typedef struct {logic we; logic [4:0] wa; logic [7:0] wd, w; logic [2:0] st; logic [7:0] d5, d6, d7;} note_t;
    logic i_clk = 0, i_rst_b = 0, i_instr_valid = 0, i_avs_read = 0, i_avs_write = 0, vld_q = 0;
    logic [11:0] i_instr = 12'h000;
    logic [4:0]  i_avs_address = 5'h00;
    logic [31:0] i_avs_writedata = 32'h0;
    logic [3:0]  i_avs_byteenable = 4'hf;
    logic [7:0]  i_file_rdata, o_file_wdata, o_wreg, o_dir5, o_dir6, o_dir7, ew, fv, r;
    logic [4:0]  o_file_waddr;
    logic [2:0]  o_status, est;
    logic [31:0] o_avs_readdata;
    logic        o_file_we, o_avs_waitrequest, en;
    logic [7:0]  em [0:31];
    logic [7:0]  ed [5:7];
    note_t       nq [$];
    note_t       mn;
    logic [31:0] rq [$];
    int          err_total = 0, total_checks = 0;

    // ********************************************
    // Clock, design and far side
    // ********************************************
    always #2.5 i_clk = ~i_clk;

    subtract_swap_dirload_exec subtract_swap_dirload_exec_inst (.i_clk(i_clk), .i_rst_b(i_rst_b),
        .i_instr_valid(i_instr_valid), .i_instr(i_instr), .i_file_rdata(i_file_rdata), .o_file_we(o_file_we),
        .o_file_waddr(o_file_waddr), .o_file_wdata(o_file_wdata), .o_wreg(o_wreg), .o_status(o_status),
        .o_dir5(o_dir5), .o_dir6(o_dir6), .o_dir7(o_dir7), .i_avs_address(i_avs_address),
        .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
        .i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(o_avs_readdata),
        .o_avs_waitrequest(o_avs_waitrequest));

    file_space_model file_space_model_inst (.i_clk(i_clk), .i_valid(i_instr_valid), .i_raddr(i_instr[4:0]),
        .o_rdata(i_file_rdata), .i_we(o_file_we), .i_waddr(o_file_waddr), .i_wdata(o_file_wdata));

    // ********************************************
    // Shared tasks
    // ********************************************
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic end_of_test();
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : end_of_test

    // One bus cycle held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d, input logic [3:0] be);
        int n;
        n = 0;
        @(posedge i_clk);
        i_avs_read <= !wr;
        i_avs_write <= wr;
        i_avs_address <= a;
        i_avs_writedata <= d;
        i_avs_byteenable <= be;
        do begin
            @(posedge i_clk);
            n++;
        end while (o_avs_waitrequest !== 1'b0 && n < 50);
        if (n >= 50) chk("waitrequest", 0, 1);
        i_avs_read <= 1'b0;
        i_avs_write <= 1'b0;
    endtask : bus

    task automatic rd(input logic [4:0] a, input logic [31:0] e);
        rq.push_back(e);
        bus(1'b0, a, 32'h0, 4'hf);
    endtask : rd

    // Write and track its effect on the expected state
    task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [3:0] be);
        bus(1'b1, a, d, be);
        if (be[0] && a == 5'h00) en = d[0];
        if (be[0] && a == 5'h04) ew = d[7:0];
        if (be[0] && a == 5'h08) est = d[2:0];
    endtask : wr

    task automatic poke(input logic [4:0] f, input logic [7:0] v);
        file_space_model_inst.mem[f] = v;
        em[f] = v;
    endtask : poke

    // Present one word and note what it must leave behind
    task automatic ins(input logic [11:0] w);
        note_t n;
        @(posedge i_clk);
        i_instr_valid <= 1'b1;
        i_instr <= w;
        fv = em[w[4:0]];
        n.we = 1'b0;
        if (en && (w[11:6] == 6'h02 || w[11:6] == 6'h0e)) begin
            if (w[11:6] == 6'h02) begin
                r = fv - ew;
                est = {r == 8'h00, fv[3:0] >= ew[3:0], fv >= ew};
            end else r = {fv[3:0], fv[7:4]};
            if (w[5]) begin
                em[w[4:0]] = r;
                n.we = 1'b1;
                n.wa = w[4:0];
                n.wd = r;
            end else ew = r;
        end else if (en && w[11:3] == 9'h000 && w[2:0] >= 3'h5) ed[w[2:0]] = ew;
        n.w = ew;
        n.st = est;
        n.d5 = ed[5];
        n.d6 = ed[6];
        n.d7 = ed[7];
        nq.push_back(n);
    endtask : ins

    task automatic idle();
        @(posedge i_clk);
        i_instr_valid <= 1'b0;
    endtask : idle

    // ********************************************
    // Monitor: results of the word taken at the previous edge
    // ********************************************
    always @(posedge i_clk) begin
        if (vld_q && nq.size() > 0) begin
            mn = nq.pop_front();
            chk("file_we", mn.we, o_file_we);
            if (mn.we) chk("file_waddr", mn.wa, o_file_waddr);
            if (mn.we) chk("file_wdata", mn.wd, o_file_wdata);
            chk("wreg", mn.w, o_wreg);
            chk("status", mn.st, o_status);
            chk("dirs", {mn.d5, mn.d6, mn.d7}, {o_dir5, o_dir6, o_dir7});
        end
        if (i_avs_read && o_avs_waitrequest === 1'b0 && rq.size() > 0) chk("readdata", rq.pop_front(), o_avs_readdata);
        vld_q <= i_instr_valid;
    end

    initial begin
        #100000;
        err_total++;
        end_of_test();
    end

    // ********************************************
    // Main sequence
    // ********************************************
    initial begin
        void'($urandom(83737));
        for (int i = 0; i < 32; i++) poke(5'(i), 8'($urandom));
        ew = 8'h00;
        est = 3'h0;
        en = 1'b1;
        ed = '{8'hff, 8'hff, 8'hff};
        repeat (6) @(posedge i_clk);
        i_rst_b <= 1'b1;
        // Reset values, read-only, unmapped, misaligned, lane 0 off
        rd(5'h00, 32'h1);
        rd(5'h04, 32'h0);
        rd(5'h08, 32'h0);
        rd(5'h0c, 32'hff);
        rd(5'h1c, 32'h0);
        rd(5'h02, 32'h0);
        wr(5'h10, 32'h12, 4'hf);
        rd(5'h10, 32'hff);
        wr(5'h04, 32'h77, 4'he);
        rd(5'h04, 32'h0);
        // Subtract: positive, back to back on one file (negative), zero
        poke(5'h03, 8'h03);
        poke(5'h04, 8'h02);
        wr(5'h04, 32'h2, 4'hf);
        ins(12'h0a3);
        ins(12'h0a3);
        ins(12'h0a4);
        ins(12'h083);
        idle();
        rd(5'h08, {29'h0, est});
        // Swap both ways, flags preserved
        wr(5'h08, 32'h6, 4'hf);
        poke(5'h05, 8'ha5);
        ins(12'h385);
        ins(12'h3a5);
        ins(12'h3a5);
        // Direction load to every port, and ignored operands
        idle();
        wr(5'h04, 32'ha5, 4'hf);
        for (int p = 0; p < 8; p++) ins({9'h000, 3'(p)});
        idle();
        rd(5'h14, {24'h0, ed[7]});
        // Execution disabled: nothing changes
        wr(5'h00, 32'h0, 4'hf);
        ins(12'h0a3);
        ins(12'h006);
        idle();
        wr(5'h00, 32'h1, 4'hf);
        // Random mix with occasional working register loads
        repeat (400) begin
            if ($urandom % 8 == 0) begin
                idle();
                wr(5'h04, $urandom, 4'hf);
            end
            case ($urandom % 4)
                0: ins({6'h02, 6'($urandom)});
                1: ins({6'h0e, 6'($urandom)});
                2: ins({9'h000, 3'($urandom)});
                default: ins(12'($urandom));
            endcase
        end
        idle();
        repeat (3) @(posedge i_clk);
        end_of_test();
    end
endmodule : subtract_swap_dirload_exec_tb
